// file: rtl/qdc_dac_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module qdc_dac_ctrl
(
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  input  wire logic         link_clk,
  input  wire logic         scl_i,
  input  wire logic         sda_i,
  output logic              sda_o,
  output logic              sda_oe_n,
  input  wire logic [1:0]   addr_strap,
  output logic [11:0]       channel_a_output,
  output logic [11:0]       channel_b_output,
  output logic [11:0]       channel_c_output,
  output logic [11:0]       channel_d_output,
  output logic [3:0]        chan_pd,
  output logic [1:0]        ref_sel
);
  import qdc_pkg::*;

  qdc_link_st_t lq;
  qdc_link_st_t ln;
  qdc_core_st_t cq;
  qdc_core_st_t cn;
  logic [1:0]   lrst_q;
  logic         link_rst;
  logic         scl_new;
  logic         sda_new;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_det;
  logic         stop_det;
  logic         addr_hit;
  logic         fire;
  qdc_word_t    fw;

  // strap decode: open pin selects the middle address
  function automatic logic [1:0] strap_lsb(input logic [1:0] s);
    if (s == STRAP_VDD)
      strap_lsb = LSB_VDD;
    else if (s == STRAP_OPEN)
      strap_lsb = LSB_OPEN;
    else
      strap_lsb = LSB_GND;
  endfunction

  // readback byte: last committed command, then ones past its end
  function automatic logic [7:0] rd_byte(input qdc_word_t w,
                                         input logic [1:0] idx);
    case (idx)
      2'h0:    rd_byte = w.cmd;
      2'h1:    rd_byte = w.hi;
      2'h2:    rd_byte = w.lo;
      default: rd_byte = READ_FILL;
    endcase
  endfunction

  // release for a one bit, pull low for a zero bit
  function automatic logic tx_rel(input logic [7:0] b,
                                  input logic [3:0] n);
    tx_rel = b[3'(4'h7 - n)];
  endfunction

  // link reset: asserts at once, releases on link_clk edges
  always_ff @(posedge link_clk or posedge sys_rst)
  begin
    if (sys_rst)
      lrst_q <= 2'b11;
    else
      lrst_q <= {lrst_q[0], 1'b0};
  end
  assign link_rst = lrst_q[1];

  // filtered line levels: a change counts once stages two and three agree
  assign scl_new  = (lq.scl_sy[1] == lq.scl_sy[2]) ? lq.scl_sy[2]
                                                   : lq.scl_f;
  assign sda_new  = (lq.sda_sy[1] == lq.sda_sy[2]) ? lq.sda_sy[2]
                                                   : lq.sda_f;
  assign scl_rise = scl_new & ~lq.scl_f;
  assign scl_fall = ~scl_new & lq.scl_f;
  // data edges only count while the clock line stays high
  assign start_det = lq.scl_f & scl_new & lq.sda_f & ~sda_new;
  assign stop_det  = lq.scl_f & scl_new & ~lq.sda_f & sda_new;
  assign addr_hit  = (lq.shreg[7:1] == {ADDR_HI, lq.addr_lsb})
                   || (lq.shreg == BCAST_ADDR);

  // link engine: scl is only ever sampled, never driven
  always_comb
  begin
    ln        = lq;
    ln.scl_sy = {lq.scl_sy[1:0], scl_i};
    ln.sda_sy = {lq.sda_sy[1:0], sda_i};
    ln.scl_f  = scl_new;
    ln.sda_f  = sda_new;
    // strap is caught once, on the first edge after reset release
    if (!lq.strap_done)
    begin
      ln.strap_done = 1'b1;
      ln.addr_lsb   = strap_lsb(addr_strap);
    end
    if (start_det)
    begin
      // a repeated start lands here too and simply restarts decoding
      ln.active   = 1'b1;
      ln.rw       = 1'b0;
      ln.phase    = PH_BITS;
      ln.bitcnt   = 4'h0;
      ln.byte_idx = 2'h0;
      ln.rd_idx   = 2'h0;
      ln.sda_rel  = 1'b1;
    end
    else if (stop_det)
    begin
      // a half-received pair is dropped, nothing was committed yet
      ln.active  = 1'b0;
      ln.phase   = PH_BITS;
      ln.sda_rel = 1'b1;
    end
    else if (lq.active && scl_rise)
    begin
      case (lq.phase)
        PH_BITS:
        begin
          ln.shreg  = {lq.shreg[6:0], sda_new};
          ln.bitcnt = 4'(lq.bitcnt + 4'h1);
        end
        PH_ACK_MST:
        begin
          // a not-acknowledge ends our part until stop or start
          if (sda_new)
            ln.phase = PH_IGNORE;
        end
        default: ;
      endcase
    end
    else if (lq.active && scl_fall)
    begin
      case (lq.phase)
        PH_BITS:
        begin
          if (lq.bitcnt == BYTE_BITS)
          begin
            ln.bitcnt = 4'h0;
            if (lq.rw)
            begin
              // byte sent: let the master acknowledge on the ninth pulse
              ln.sda_rel = 1'b1;
              ln.phase   = PH_ACK_MST;
              ln.rd_idx  = (lq.rd_idx == 2'h3) ? lq.rd_idx
                                               : 2'(lq.rd_idx + 2'h1);
            end
            else
            begin
              ln.sda_rel = 1'b0;
              ln.phase   = PH_ACK_DEV;
              case (lq.byte_idx)
                2'h0:
                begin
                  if (addr_hit)
                  begin
                    ln.rw       = lq.shreg[0];
                    ln.byte_idx = 2'h1;
                  end
                  else
                  begin
                    ln.sda_rel = 1'b1;
                    ln.phase   = PH_IGNORE;
                  end
                end
                2'h1:
                begin
                  ln.cmd      = lq.shreg;
                  ln.byte_idx = 2'h2;
                end
                2'h2:
                begin
                  ln.hi       = lq.shreg;
                  ln.byte_idx = 2'h3;
                end
                default:
                begin
                  // pair complete: publish word and flip the toggle on the same edge
                  ln.word     = '{cmd: lq.cmd, hi: lq.hi, lo: lq.shreg};
                  ln.req_tgl  = ~lq.req_tgl;
                  ln.byte_idx = 2'h1;
                end
              endcase
            end
          end
          else if (lq.rw)
            ln.sda_rel = tx_rel(rd_byte(lq.word, lq.rd_idx),
                                lq.bitcnt);
        end
        PH_ACK_DEV:
        begin
          // low stays until the falling edge that ends the ninth pulse
          ln.phase   = PH_BITS;
          ln.sda_rel = lq.rw ? tx_rel(rd_byte(lq.word, lq.rd_idx), 4'h0)
                             : 1'b1;
        end
        PH_ACK_MST:
        begin
          ln.phase   = PH_BITS;
          ln.sda_rel = tx_rel(rd_byte(lq.word, lq.rd_idx), 4'h0);
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge link_clk or posedge link_rst)
  begin
    if (link_rst)
      lq <= LINK_RST;
    else
      lq <= ln;
  end

  // open drain: the pad only ever pulls low
  assign sda_o    = 1'b0;
  assign sda_oe_n = lq.sda_rel;

  // command word crossing: toggle seen through three flops, word held
  // stable by the link until the next pair, many microseconds later
  assign fire = (cq.req_sy[1] == cq.req_sy[2])
              && (cq.req_sy[2] != cq.req_seen);
  assign fw   = lq.word;

  // channel registers: pending feeds output, outputs drive the converters
  always_comb
  begin
    cn        = cq;
    cn.req_sy = {cq.req_sy[1:0], lq.req_tgl};
    if (fire)
    begin
      cn.req_seen = cq.req_sy[2];
      case (op_of(fw.cmd))
        OP_CODE:
          for (int i = 0; i < NUM_CH; i++)
            if (chan_hit(fw.cmd, 2'(i)))
              cn.code[i] = data12(fw);
        OP_LOAD:
          for (int i = 0; i < NUM_CH; i++)
            if (chan_hit(fw.cmd, 2'(i)))
              cn.dac[i] = cq.code[i];
        OP_CODE_LOAD:
          for (int i = 0; i < NUM_CH; i++)
            if (chan_hit(fw.cmd, 2'(i)))
            begin
              cn.code[i] = data12(fw);
              cn.dac[i]  = data12(fw);
            end
        // power state never touches the codes, so they come back intact
        OP_POWER:
          cn.pd = fw.hi[3:0];
        OP_SOFT_CLEAR:
          for (int i = 0; i < NUM_CH; i++)
          begin
            cn.code[i] = CODE_ZERO;
            cn.dac[i]  = CODE_ZERO;
          end
        OP_SOFT_RESET:
        begin
          for (int i = 0; i < NUM_CH; i++)
          begin
            cn.code[i] = CODE_ZERO;
            cn.dac[i]  = CODE_ZERO;
          end
          cn.pd      = 4'h0;
          cn.ref_sel = REF_EXT;
        end
        OP_REF:
          cn.ref_sel = fw.hi[1:0];
        default: ;
      endcase
    end
  end

  // power-on: codes zero, external reference, all channels powered
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cq         <= '0;
      cq.ref_sel <= REF_EXT;
    end
    else
      cq <= cn;
  end

  // only the output registers reach the converter pins
  assign channel_a_output = cq.dac[0];
  assign channel_b_output = cq.dac[1];
  assign channel_c_output = cq.dac[2];
  assign channel_d_output = cq.dac[3];
  assign chan_pd          = cq.pd;
  assign ref_sel          = cq.ref_sel;

  property p_ack_low;
    @(posedge link_clk) disable iff (link_rst)
    (lq.phase == PH_ACK_DEV) |-> !sda_oe_n;
  endproperty
  a_ack_low: assert property (p_ack_low)
    else $error("ack phase without sda pulled low");
  property p_commit_pair;
    @(posedge link_clk) disable iff (link_rst)
    $changed(lq.req_tgl) |-> ($past(lq.byte_idx) == 2'h3)
                             && (lq.byte_idx == 2'h1);
  endproperty
  a_commit_pair: assert property (p_commit_pair)
    else $error("command word committed before a full pair");
  property p_start;
    @(posedge link_clk) disable iff (link_rst)
    start_det |=> lq.active && (lq.bitcnt == 4'h0)
                  && (lq.byte_idx == 2'h0) && lq.sda_rel;
  endproperty
  a_start: assert property (p_start)
    else $error("start did not restart decoding");
  property p_idle_rel;
    @(posedge link_clk) disable iff (link_rst)
    (!lq.active || stop_det) |=> sda_oe_n;
  endproperty
  a_idle_rel: assert property (p_idle_rel)
    else $error("sda driven while bus idle");
  property p_load;
    @(posedge ref_clk) disable iff (sys_rst)
    (fire && op_of(fw.cmd) == OP_LOAD && chan_hit(fw.cmd, 2'h1))
      |=> channel_b_output == $past(cq.code[1]);
  endproperty
  a_load: assert property (p_load)
    else $error("transfer did not copy pending into output");
  property p_code_only;
    @(posedge ref_clk) disable iff (sys_rst)
    (fire && op_of(fw.cmd) == OP_CODE && chan_hit(fw.cmd, 2'h1))
      |=> $stable(cq.dac[1]) && (cq.code[1] == $past(data12(fw)));
  endproperty
  a_code_only: assert property (p_code_only)
    else $error("pending write wrong or output disturbed");
  property p_code_load;
    @(posedge ref_clk) disable iff (sys_rst)
    (fire && op_of(fw.cmd) == OP_CODE_LOAD && chan_hit(fw.cmd, 2'h1))
      |=> (channel_b_output == cq.code[1])
          && (cq.code[1] == $past(data12(fw)));
  endproperty
  a_code_load: assert property (p_code_load)
    else $error("write-update did not load both registers");
  property p_clear;
    @(posedge ref_clk) disable iff (sys_rst)
    (fire && (op_of(fw.cmd) == OP_SOFT_CLEAR
              || op_of(fw.cmd) == OP_SOFT_RESET))
      |=> (cq.code == '0) && (cq.dac == '0);
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear or reset left a nonzero code");
  property p_soft_ref;
    @(posedge ref_clk) disable iff (sys_rst)
    (fire && op_of(fw.cmd) == OP_SOFT_RESET) |=> ref_sel == REF_EXT;
  endproperty
  a_soft_ref: assert property (p_soft_ref)
    else $error("soft reset kept an internal reference");
  property p_pd_keep;
    @(posedge ref_clk) disable iff (sys_rst)
    (fire && op_of(fw.cmd) == OP_POWER)
      |=> $stable(cq.dac) && $stable(cq.code)
          && (chan_pd == $past(fw.hi[3:0]));
  endproperty
  a_pd_keep: assert property (p_pd_keep)
    else $error("power command disturbed stored codes");
endmodule // qdc_dac_ctrl
`default_nettype wire

// file: rtl/qdc_pkg.sv
`default_nettype none
package qdc_pkg;

  // channel layout and code width
  localparam int          NUM_CH    = 4;
  localparam int          CODE_W    = 12;
  localparam logic [11:0] CODE_ZERO = 12'h000;

  // serial addressing: fixed upper bits, broadcast byte, read fill
  localparam logic [4:0] ADDR_HI    = 5'h03;
  localparam logic [7:0] BCAST_ADDR = 8'h10;
  localparam logic [7:0] READ_FILL  = 8'hff;
  localparam logic [3:0] BYTE_BITS  = 4'h8;

  // address strap input encodings and the address bits they select
  localparam logic [1:0] STRAP_VDD  = 2'h0;
  localparam logic [1:0] STRAP_OPEN = 2'h1;
  localparam logic [1:0] LSB_VDD    = 2'h0;
  localparam logic [1:0] LSB_OPEN   = 2'h2;
  localparam logic [1:0] LSB_GND    = 2'h3;

  // command byte: opcode in the upper nibble, channel select below
  localparam int         OP_LSB        = 4;
  localparam logic [3:0] OP_CODE       = 4'h0;
  localparam logic [3:0] OP_LOAD       = 4'h1;
  localparam logic [3:0] OP_CODE_LOAD  = 4'h2;
  localparam logic [3:0] OP_POWER      = 4'h4;
  localparam logic [3:0] OP_SOFT_CLEAR = 4'h5;
  localparam logic [3:0] OP_SOFT_RESET = 4'h6;
  localparam logic [3:0] OP_REF        = 4'h7;
  localparam logic [3:0] SEL_ALL_MIN   = 4'h4;

  // reference selection codes
  localparam logic [1:0] REF_EXT   = 2'h0;
  localparam logic [1:0] REF_2V048 = 2'h1;
  localparam logic [1:0] REF_2V500 = 2'h2;
  localparam logic [1:0] REF_4V096 = 2'h3;

  typedef enum logic [1:0] {PH_BITS, PH_ACK_DEV, PH_ACK_MST, PH_IGNORE}
    qdc_phase_t;

  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] hi;
    logic [7:0] lo;
  } qdc_word_t;

  typedef struct packed {
    logic [2:0] scl_sy;
    logic [2:0] sda_sy;
    logic       scl_f;
    logic       sda_f;
    logic       active;
    logic       rw;
    qdc_phase_t phase;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [1:0] byte_idx;
    logic [1:0] rd_idx;
    logic       sda_rel;
    logic [7:0] cmd;
    logic [7:0] hi;
    qdc_word_t  word;
    logic       req_tgl;
    logic       strap_done;
    logic [1:0] addr_lsb;
  } qdc_link_st_t;

  typedef struct packed {
    logic [2:0]             req_sy;
    logic                   req_seen;
    logic [3:0][CODE_W-1:0] code;
    logic [3:0][CODE_W-1:0] dac;
    logic [3:0]             pd;
    logic [1:0]             ref_sel;
  } qdc_core_st_t;

  localparam qdc_link_st_t LINK_RST = '{
    scl_sy: 3'h7, sda_sy: 3'h7, scl_f: 1'b1, sda_f: 1'b1, active: 1'b0,
    rw: 1'b0, phase: PH_BITS, bitcnt: 4'h0, shreg: 8'h00,
    byte_idx: 2'h0, rd_idx: 2'h0, sda_rel: 1'b1, cmd: 8'h00, hi: 8'h00,
    word: 24'h000000, req_tgl: 1'b0, strap_done: 1'b0, addr_lsb: 2'h0};

  // opcode field of a command byte
  function automatic logic [3:0] op_of(input logic [7:0] cmd);
    op_of = cmd[OP_LSB +: 4];
  endfunction

  // channel select: values from SEL_ALL_MIN upward hit every channel
  function automatic logic chan_hit(input logic [7:0] cmd,
                                    input logic [1:0] ch);
    chan_hit = (cmd[3:0] >= SEL_ALL_MIN) || (cmd[3:0] == {2'h0, ch});
  endfunction

  // twelve-bit code, left aligned across the two data bytes
  function automatic logic [11:0] data12(input qdc_word_t w);
    data12 = {w.hi, w.lo[7:4]};
  endfunction

endpackage
`default_nettype wire

// file: verification/qdc_i2c_master.sv
`timescale 1ns/10ps
`default_nettype none
// behavioural bus master: pushes the clock, data is open drain (1=release)
module qdc_i2c_master #(
  parameter time TQ = 150
) (
  output var logic scl,
  output var logic sda_m,
  input  wire logic sda
);

  // both lines released high while the bus is idle
  initial
  begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end

  // one pulse; data moves only while the clock is low, and the line is
  // sampled at the rise and mid-high, and reads as a one if either sample is high
  task automatic pulse(input logic b, output logic s);
    logic a;
    sda_m = b;
    #TQ;
    scl = 1'b1;
    a = sda;
    #TQ;
    s = a | sda;
    #TQ;
    scl = 1'b0;
    #TQ;
  endtask

  // works from idle and as a repeated start
  task automatic start;
    sda_m = 1'b1;
    #TQ;
    scl = 1'b1;
    #TQ;
    sda_m = 1'b0;
    #TQ;
    scl = 1'b0;
    #TQ;
  endtask

  task automatic stop;
    sda_m = 1'b0;
    #TQ;
    scl = 1'b1;
    #TQ;
    sda_m = 1'b1;
    #(4*TQ);
  endtask

  // eight bits msb first, then a ninth pulse for the answer
  task automatic wr(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      pulse(b[i], s);
    pulse(1'b1, s);
    ack = ~s;
  endtask

  // nine pulses per byte; nack ends the read
  task automatic rd(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      pulse(1'b1, s);
      d[i] = s;
    end
    pulse(nack, s);
  endtask

endmodule // qdc_i2c_master
`default_nettype wire

// file: verification/qdc_dac_ctrl_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module qdc_dac_ctrl_tb_top;
  import qdc_pkg::*;

  logic        ref_clk, link_clk, sys_rst;
  logic [1:0]  addr_strap;
  logic        scl, sda_m, sda_o, sda_oe_n, sda;
  logic [11:0] out_a, out_b, out_c, out_d;
  logic [3:0]  chan_pd;
  logic [1:0]  ref_sel;
  int          errors;
  int          n_checks;

  localparam logic [7:0] DEV_W = {ADDR_HI, LSB_OPEN, 1'b0};
  localparam logic [7:0] DEV_R = {ADDR_HI, LSB_OPEN, 1'b1};

  // pulled-up wire: low whenever either party pulls
  assign sda = (sda_oe_n ? 1'b1 : sda_o) & sda_m;

  qdc_dac_ctrl dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .link_clk(link_clk),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .addr_strap(addr_strap), .channel_a_output(out_a),
    .channel_b_output(out_b), .channel_c_output(out_c),
    .channel_d_output(out_d), .chan_pd(chan_pd), .ref_sel(ref_sel));

  // serial clock faster than fast mode to keep the run short; the
  // link still sees the low phase for ten of its cycles
  qdc_i2c_master mst (.scl(scl), .sda_m(sda_m), .sda(sda));

  // core clock and an unrelated link clock
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = ~link_clk;
  end

  task automatic chk(input string nm, input logic [11:0] e,
                     input logic [11:0] g);
    n_checks++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_ch(input logic [11:0] a, b, c, d);
    @(negedge ref_clk);
    chk("channel_a_output", a, out_a);
    chk("channel_b_output", b, out_b);
    chk("channel_c_output", c, out_c);
    chk("channel_d_output", d, out_d);
  endtask

  task automatic chk_ctl(input logic [3:0] pd, input logic [1:0] rs);
    @(negedge ref_clk);
    chk("chan_pd", {8'h0, pd}, {8'h0, chan_pd});
    chk("ref_sel", {10'h0, rs}, {10'h0, ref_sel});
  endtask

  task automatic put(input logic [7:0] b, input logic ack_exp);
    logic a;
    mst.wr(b, a);
    chk("ack", {11'h0, ack_exp}, {11'h0, a});
  endtask

  // command byte plus its data pair, all expected to be acknowledged
  task automatic cmd(input logic [3:0] op, sel, input logic [7:0] hi, lo);
    put({op, sel}, 1'b1);
    put(hi, 1'b1);
    put(lo, 1'b1);
  endtask

  task automatic t_reset;
    chk_ch(12'h0, 12'h0, 12'h0, 12'h0);
    chk_ctl(4'h0, REF_EXT);
    chk("sda_oe_n", 12'h1, {11'h0, sda_oe_n});
    chk("sda_o", 12'h0, {11'h0, sda_o});
    $display("done reset values");
  endtask

  task automatic t_bad_addr;
    mst.start;
    put({ADDR_HI, LSB_GND, 1'b0}, 1'b0);
    mst.stop;
    $display("done foreign address");
  endtask

  task automatic t_pending;
    mst.start;
    put(DEV_W, 1'b1);
    cmd(OP_CODE, 4'h1, 8'hab, 8'hc0);
    chk_ch(12'h0, 12'h0, 12'h0, 12'h0);
    cmd(OP_LOAD, 4'h1, 8'h00, 8'h00);
    chk_ch(12'h0, 12'habc, 12'h0, 12'h0);
    mst.stop;
    $display("done pending and transfer");
  endtask

  task automatic t_power;
    mst.start;
    put(DEV_W, 1'b1);
    cmd(OP_POWER, 4'h0, 8'h0f, 8'h00);
    chk_ctl(4'hf, REF_EXT);
    cmd(OP_CODE_LOAD, 4'h2, 8'h45, 8'h60);
    chk_ch(12'h0, 12'habc, 12'h456, 12'h0);
    cmd(OP_POWER, 4'h0, 8'h00, 8'h00);
    chk_ctl(4'h0, REF_EXT);
    chk_ch(12'h0, 12'habc, 12'h456, 12'h0);
    mst.stop;
    $display("done power-down");
  endtask

  task automatic t_early_stop;
    mst.start;
    put(DEV_W, 1'b1);
    put({OP_CODE_LOAD, 4'h2}, 1'b1);
    put(8'hff, 1'b1);
    mst.stop;
    chk_ch(12'h0, 12'habc, 12'h456, 12'h0);
    $display("done early stop");
  endtask

  task automatic t_restart;
    mst.start;
    put(DEV_W, 1'b1);
    put({OP_CODE_LOAD, 4'h3}, 1'b1);
    mst.start;
    put(DEV_W, 1'b1);
    cmd(OP_CODE_LOAD, 4'h3, 8'h78, 8'h90);
    mst.stop;
    chk_ch(12'h0, 12'habc, 12'h456, 12'h789);
    $display("done repeated start");
  endtask

  // last committed word comes back, then ones
  task automatic t_readback;
    logic [31:0] exp;
    logic [7:0]  d;
    exp = 32'h237890ff;
    mst.start;
    put(DEV_R, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      mst.rd(i == 3, d);
      chk("read byte", {4'h0, exp[31-8*i -: 8]}, {4'h0, d});
    end
    mst.stop;
    chk("sda_oe_n", 12'h1, {11'h0, sda_oe_n});
    $display("done readback");
  endtask

  task automatic t_ref;
    mst.start;
    put(DEV_W, 1'b1);
    for (int r = 1; r < 4; r++)
    begin
      cmd(OP_REF, 4'h0, {6'h0, r[1:0]}, 8'h00);
      chk_ctl(4'h0, r[1:0]);
    end
    mst.stop;
    $display("done reference select");
  endtask

  task automatic t_clear;
    mst.start;
    put(DEV_W, 1'b1);
    cmd(OP_CODE_LOAD, SEL_ALL_MIN, 8'h33, 8'h30);
    chk_ch(12'h333, 12'h333, 12'h333, 12'h333);
    cmd(OP_SOFT_CLEAR, 4'h0, 8'h00, 8'h00);
    chk_ch(12'h0, 12'h0, 12'h0, 12'h0);
    chk_ctl(4'h0, REF_4V096);
    mst.stop;
    $display("done soft clear");
  endtask

  task automatic t_soft_reset;
    mst.start;
    put(DEV_W, 1'b1);
    cmd(OP_CODE_LOAD, 4'hf, 8'h55, 8'h50);
    cmd(OP_POWER, 4'h0, 8'h05, 8'h00);
    chk_ch(12'h555, 12'h555, 12'h555, 12'h555);
    chk_ctl(4'h5, REF_4V096);
    cmd(OP_SOFT_RESET, 4'h0, 8'h00, 8'h00);
    chk_ch(12'h0, 12'h0, 12'h0, 12'h0);
    chk_ctl(4'h0, REF_EXT);
    mst.stop;
    $display("done soft reset");
  endtask

  // broadcast write, then a mid-run reset that reads the strap again
  task automatic t_rst_strap;
    mst.start;
    put(BCAST_ADDR, 1'b1);
    cmd(OP_CODE_LOAD, 4'h0, 8'h12, 8'h30);
    cmd(OP_REF, 4'h0, 8'h02, 8'h00);
    mst.stop;
    chk_ch(12'h123, 12'h0, 12'h0, 12'h0);
    chk_ctl(4'h0, REF_2V500);
    @(negedge ref_clk);
    sys_rst = 1'b1;
    addr_strap = STRAP_VDD;
    repeat (8) @(negedge link_clk);
    @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (12) @(negedge link_clk);
    chk_ch(12'h0, 12'h0, 12'h0, 12'h0);
    chk_ctl(4'h0, REF_EXT);
    mst.start;
    put(DEV_W, 1'b0);
    mst.stop;
    mst.start;
    put({ADDR_HI, LSB_VDD, 1'b0}, 1'b1);
    mst.stop;
    $display("done broadcast and strap");
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // reset long enough for the link synchroniser, then every scenario
  initial
  begin
    errors = 0;
    n_checks = 0;
    sys_rst = 1'b1;
    addr_strap = STRAP_OPEN;
    repeat (8) @(negedge link_clk);
    @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (12) @(negedge link_clk);
    t_reset;
    t_bad_addr;
    t_pending;
    t_power;
    t_early_stop;
    t_restart;
    t_readback;
    t_ref;
    t_clear;
    t_soft_reset;
    t_rst_strap;
    close_out;
  end

  // the scenarios need about 400 us of serial traffic; the limit keeps a
  // hung run under about 100000 core clock cycles
  initial
  begin
    #480000;
    errors++;
    $display("watchdog expired");
    close_out;
  end

endmodule // qdc_dac_ctrl_tb_top
`default_nettype wire
